// >>> bench/ccrp_pwr_switch.sv
// Model of the external card power switch
`timescale 1ns/1ps
`default_nettype none
module ccrp_pwr_switch (
   input  wire logic       oe,   // Select pins driven
   input  wire logic [3:0] sel,  // Main and programming selects
   output logic      [3:0] code  // Supplies applied to the card
);
   // Released selects sit on pull-downs, so the card is left unpowered
   assign code = oe ? sel : 4'h0;
endmodule // ccrp_pwr_switch
`default_nettype wire

// >>> bench/ccrp_top_asserts.sv
// Checker for the card reset and power-pin block
`timescale 1ns/1ps
`default_nettype none
`include "ccrp_defines.vh"
module ccrp_top_asserts (
   input wire logic       core_clk, nrst, global_reset_in_n, host_bus_reset_in_n, // Clock, resets
   input wire logic       suspend_in_n, cfg_wr, pme_set, pme_clr, sel_oe, // Controls
   input wire logic       pme_status, func_ready, card_supply_sel0, card_supply_sel1, // Status
   input wire logic       card_prog_supply_sel0, card_prog_supply_sel1, // Programming select
   input wire logic [1:0] cfg_vcc_sel, cfg_vpp_sel, state // Codes and state
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Pins idle; windows allow two sync flops plus the output flop
   wire logic       ok = global_reset_in_n & host_bus_reset_in_n & suspend_in_n;
   wire logic [3:0] codes = {card_supply_sel1, card_supply_sel0, card_prog_supply_sel1,
                             card_prog_supply_sel0};
   property p_gz; (!global_reset_in_n)[*3] |=> !sel_oe; endproperty
   a_gz: assert property (p_gz) else $error("oe on in global reset");
   property p_bz; (!host_bus_reset_in_n)[*3] |=> !sel_oe; endproperty
   a_bz: assert property (p_bz) else $error("oe on in bus reset");
   property p_gclr; (!global_reset_in_n && suspend_in_n && !pme_set)[*5] |=> !codes && !pme_status; endproperty
   a_gclr: assert property (p_gclr) else $error("state kept");
   property p_bidle; (!host_bus_reset_in_n)[*4] |=> !func_ready; endproperty
   a_bidle: assert property (p_bidle) else $error("runs in reset");
   property p_hold; (!suspend_in_n)[*5] |=> $stable(codes); endproperty
   a_hold: assert property (p_hold) else $error("codes lost");
   property p_pme; (global_reset_in_n && !host_bus_reset_in_n && !pme_set)[*4] |=> $stable(pme_status); endproperty
   a_pme: assert property (p_pme) else $error("wake lost");
   property p_wr; ok[*4] ##0 (cfg_wr && func_ready) ##1 ok[*2] |-> codes == {$past(cfg_vcc_sel, 2), $past(cfg_vpp_sel, 2)}; endproperty
   a_wr: assert property (p_wr) else $error("code wrong");
   property p_run; ok[*4] |=> func_ready && state == `CCRP_ST_RUN; endproperty
   a_run: assert property (p_run) else $error("not running");
endmodule // ccrp_top_asserts
bind ccrp_top ccrp_top_asserts u_chk (.*);
`default_nettype wire

// >>> bench/tb_ccrp_top.sv
// Self-checking bench for the card reset and power-pin block
`timescale 1ns/1ps
`default_nettype none
`include "ccrp_defines.vh"
module tb_ccrp_top;
   logic       core_clk = 1'b0, nrst = 1'b0, global_reset_in_n = 1'b0, suspend_in_n = 1'b1;
   logic       host_bus_reset_in_n = 1'b1, cfg_wr = 1'b0, pme_set = 1'b0, pme_clr = 1'b0;
   logic [1:0] cfg_vcc_sel = 2'h0, cfg_vpp_sel = 2'h0;
   wire  logic card_supply_sel0, card_supply_sel1, card_prog_supply_sel0, card_prog_supply_sel1;
   wire  logic sel_oe, pme_status, func_ready;
   wire  logic [1:0] state;
   wire  logic [3:0] sup, pins;
   int         err_total = 0, checked = 0;
   // Each row sets both codes; all four values of each appear
   logic [3:0] rows [4] = '{4'h1, 4'h6, 4'hb, 4'hc};
   assign pins = {card_supply_sel1, card_supply_sel0, card_prog_supply_sel1, card_prog_supply_sel0};
   always #2.5 core_clk = ~core_clk;
   ccrp_top DUT (.*);
   ccrp_pwr_switch SW (.oe(sel_oe), .sel(pins), .code(sup));
   // Sample one ns after the edge so register updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Write strobe with codes and, when bit 0 is set, a wake-clear pulse alongside
   task automatic put(input logic [4:0] c);
      @(posedge core_clk) {cfg_wr, cfg_vcc_sel, cfg_vpp_sel, pme_clr} <= {1'b1, c};
      @(posedge core_clk) {cfg_wr, pme_clr} <= 2'h0;
      cyc(3);
   endtask
   task automatic summarize;
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      {nrst, global_reset_in_n} <= 2'h3;
      cyc(4);
      foreach (rows[i]) begin
         put({rows[i], 1'b0});
         chk({pme_status, sel_oe, sup}, {2'h1, rows[i]});
      end
      @(posedge core_clk) pme_set <= 1'b1;
      @(posedge core_clk) {pme_set, suspend_in_n} <= 2'h0;
      cyc(4);
      @(posedge core_clk) host_bus_reset_in_n <= 1'b0;
      put(5'h01);
      chk({pme_status, sel_oe, pins}, 6'h2c);
      chk({2'h0, sup}, 6'h00);
      @(posedge core_clk) global_reset_in_n <= 1'b0;
      cyc(5);
      chk({pme_status, sel_oe, pins}, 6'h2c);
      @(posedge core_clk) {global_reset_in_n, suspend_in_n} <= 2'h3;
      cyc(2);
      put(5'h1f);
      chk({pme_status, sel_oe, pins}, 6'h20);
      @(posedge core_clk) host_bus_reset_in_n <= 1'b1;
      cyc(5);
      chk({pme_status, func_ready, state, 2'h0}, {2'h3, `CCRP_ST_RUN, 2'h0});
      put(5'h0b);
      chk({pme_status, sel_oe, pins}, 6'h15);
      @(posedge core_clk) pme_set <= 1'b1;
      @(posedge core_clk) pme_set <= 1'b0;
      @(posedge core_clk) global_reset_in_n <= 1'b0;
      cyc(6);
      chk({pme_status, sel_oe, pins}, 6'h00);
      chk({func_ready, 3'h0, state}, {4'h0, `CCRP_ST_RESET});
      summarize();
   end
endmodule // tb_ccrp_top
`default_nettype wire

// >>> src/ccrp_defines.vh
// Shared constants for the card reset and power-pin block
`ifndef CCRP_DEFINES_VH
`define CCRP_DEFINES_VH
`define CCRP_SEL_W        2
`define CCRP_SEL_RST      2'h0
`define CCRP_PME_RST      1'h0
`define CCRP_CFG_RST      4'h0
`define CCRP_ST_RESET     2'h0
`define CCRP_ST_RUN       2'h1
`define CCRP_ST_SUSP      2'h2
`define CCRP_PIN_GLOBAL_RESET_IN     2
`define CCRP_PIN_HOST_BUS_RESET_IN     1
`define CCRP_PIN_SUSP     0
`endif

// >>> src/ccrp_sync.v
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ccrp_sync #(
   parameter W = 1,                   // Number of bits
   parameter [W-1:0] RST_VAL = {W{1'b0}} // Value held in reset
) (
   input  wire         core_clk,      // Bus clock
   input  wire         nrst,          // Async reset, active low
   input  wire [W-1:0] din,           // Asynchronous inputs
   output reg  [W-1:0] dout           // Synchronised outputs
);
   reg [W-1:0] meta_q;                // First stage, read only by dout
   // Each bit passes two flops before any logic sees it
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               meta_q[i] <= RST_VAL[i];
               dout[i]   <= RST_VAL[i];
            end else begin
               meta_q[i] <= din[i];
               dout[i]   <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule // ccrp_sync
`default_nettype wire

// >>> src/ccrp_top.v
// Reset, suspend and power-switch control pins of the card controller
`timescale 1ns/1ps
`default_nettype none
`include "ccrp_defines.vh"
module ccrp_top (
   input  wire       core_clk,              // Bus clock, 200 MHz
   input  wire       nrst,                  // Power-on async reset, active low
   input  wire       global_reset_in_n,     // Global reset pin, active low
   input  wire       host_bus_reset_in_n,   // Bus reset pin, active low
   input  wire       suspend_in_n,          // Suspend pin, active low
   input  wire       cfg_wr,                // Core write strobe, one cycle
   input  wire [1:0] cfg_vcc_sel,           // Requested main supply code
   input  wire [1:0] cfg_vpp_sel,           // Requested programming supply code
   input  wire       pme_set,               // Wake event pulse from core logic
   input  wire       pme_clr,               // Wake status clear pulse
   output reg        card_supply_sel0,      // Main supply select bit 0
   output reg        card_supply_sel1,      // Main supply select bit 1
   output reg        card_prog_supply_sel0, // Programming supply select bit 0
   output reg        card_prog_supply_sel1, // Programming supply select bit 1
   output reg        sel_oe,                // Output enable of select pins
   output reg        pme_status,            // Retained wake status
   output reg        func_ready,            // Block is operating
   output reg  [1:0] state                  // Current sequencer state
);
   // Synchronised pin levels, all active high inside the block
   wire       global_reset_in_s;                       // Synchronised global reset
   wire       host_bus_reset_in_s;                       // Synchronised bus reset
   wire       susp_s;                       // Synchronised suspend
   wire [2:0] pin_raw;                      // Pins turned active high
   wire [2:0] pin_sync;                     // Pins after two flops

   // Decoded reset situation, shared by every register group
   wire       any_rst;                      // Either reset pin seen
   wire       regs_shielded;                // Suspend protects contents
   wire       clr_regs;                     // Reset that clears contents
   wire       clr_wake;                     // Reset that clears wake context
   wire       wr_take;                      // Write accepted this cycle
   wire       wake_clr_take;                // Wake clear accepted this cycle

   // Sequencer, held codes and next values of the output flops
   reg  [1:0] state_d;                      // Next sequencer state
   reg  [1:0] vcc_q;                        // Held main supply code
   reg  [1:0] vcc_d;                        // Next main supply code
   reg  [1:0] vpp_q;                        // Held programming supply code
   reg  [1:0] vpp_d;                        // Next programming supply code
   reg        pme_q;                        // Held wake status
   reg        pme_d;                        // Next wake status
   reg        oe_d;                         // Next select pin enable
   reg        ready_d;                      // Next running flag

   // Pins are active low outside; turn them active high before crossing.
   // The synchroniser resets to zero so no reset is seen right after power-on.
   assign pin_raw = {~global_reset_in_n, ~host_bus_reset_in_n, ~suspend_in_n};

   // Pins cross into the clock domain first
   ccrp_sync #(.W(3), .RST_VAL(3'h0)) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .din      (pin_raw),
      .dout     (pin_sync)
   );

   // Name the synchronised pins; nothing reads the raw pins after this point
   assign global_reset_in_s = pin_sync[`CCRP_PIN_GLOBAL_RESET_IN];
   assign host_bus_reset_in_s = pin_sync[`CCRP_PIN_HOST_BUS_RESET_IN];
   assign susp_s = pin_sync[`CCRP_PIN_SUSP];

   // Suspend outranks both resets for register contents, never for the pins.
   // Keeping the shield in one place stops the groups from disagreeing.
   assign any_rst       = global_reset_in_s | host_bus_reset_in_s;
   assign regs_shielded = susp_s;
   assign clr_regs      = any_rst & ~regs_shielded;

   // Only the global reset may wipe the wake context
   assign clr_wake      = global_reset_in_s & ~regs_shielded;

   // Writes are refused silently while either reset or suspend is seen; wake clears are refused while bus reset or suspend is seen
   assign wr_take       = cfg_wr & ~any_rst & ~regs_shielded;
   assign wake_clr_take = pme_clr & ~host_bus_reset_in_s & ~regs_shielded;

   // Next state: reset wins over run; suspend wins over reset in run and suspend, not in reset.
   // A reset pulse shorter than one clock may be missed by the synchroniser.
   always @* begin
      state_d = state;
      case (state)
         `CCRP_ST_RESET: begin
            if (any_rst)
               state_d = `CCRP_ST_RESET;
            else
               state_d = `CCRP_ST_RUN;
         end
         `CCRP_ST_RUN: begin
            if (susp_s)
               state_d = `CCRP_ST_SUSP;
            else if (any_rst)
               state_d = `CCRP_ST_RESET;
            else
               state_d = `CCRP_ST_RUN;
         end
         `CCRP_ST_SUSP: begin
            if (susp_s)
               state_d = `CCRP_ST_SUSP;
            else if (any_rst)
               state_d = `CCRP_ST_RESET;
            else
               state_d = `CCRP_ST_RUN;
         end
         default: begin
            state_d = `CCRP_ST_RESET;                              // Unused code recovers
         end
      endcase
   end

   // State register
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         state <= `CCRP_ST_RESET;
      else
         state <= state_d;
   end

   // Next supply codes: hold under suspend, clear on reset, else take a write
   always @* begin
      vcc_d = vcc_q;
      vpp_d = vpp_q;
      if (regs_shielded) begin
         vcc_d = vcc_q;
         vpp_d = vpp_q;
      end else if (clr_regs) begin
         vcc_d = `CCRP_SEL_RST;
         vpp_d = `CCRP_SEL_RST;
      end else if (wr_take) begin
         vcc_d = cfg_vcc_sel;
         vpp_d = cfg_vpp_sel;
      end
   end

   // Held supply codes; both are written together, there is no half update
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         vcc_q <= `CCRP_SEL_RST;
         vpp_q <= `CCRP_SEL_RST;
      end else begin
         vcc_q <= vcc_d;
         vpp_q <= vpp_d;
      end
   end

   // Next wake status; an event is never lost to a clear in the same cycle
   always @* begin
      pme_d = pme_q;
      if (pme_set)
         pme_d = 1'b1;                                             // Set wins over clear
      else if (clr_wake)
         pme_d = `CCRP_PME_RST;
      else if (wake_clr_take)
         pme_d = 1'b0;
   end

   // Wake status register, untouched by the bus reset
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         pme_q <= `CCRP_PME_RST;
      else
         pme_q <= pme_d;
   end

   // Pins float on any reset, even under suspend, so the switch sees no code.
   // The running flag follows the next state to save one cycle of latency.
   always @* begin
      oe_d    = ~any_rst;
      ready_d = (state_d == `CCRP_ST_RUN);
   end

   // Registered pin drivers so the switch never sees a glitch
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sel_oe                <= 1'b0;
         card_supply_sel0      <= 1'b0;
         card_supply_sel1      <= 1'b0;
         card_prog_supply_sel0 <= 1'b0;
         card_prog_supply_sel1 <= 1'b0;
         pme_status            <= 1'b0;
         func_ready            <= 1'b0;
      end else begin
         sel_oe                <= oe_d;
         card_supply_sel0      <= vcc_q[0];
         card_supply_sel1      <= vcc_q[1];
         card_prog_supply_sel0 <= vpp_q[0];
         card_prog_supply_sel1 <= vpp_q[1];
         pme_status            <= pme_q;
         func_ready            <= ready_d;
      end
   end
endmodule // ccrp_top
`default_nettype wire
